// ---- core/ccf_frame_codec.sv ----
// framing and bit coding engine with shared 64-byte buffer
`timescale 1ns/100ps
module ccf_frame_codec (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    // mode selection and carrier tick
    input wire logic MODE_TYPEF,
    input wire ccf_pkg::ccf_rate_e RATE,
    input wire logic PARITY_HI_EN,
    input wire logic CARRIER_TICK,
    // processor side of the buffer
    input wire logic WR_REQ,
    input wire logic [7:0] WR_DATA,
    output logic WR_ACK,
    input wire logic RD_REQ,
    output logic [7:0] RD_DATA,
    output logic RD_ACK,
    output logic [ccf_pkg::LVL_W-1:0] BUF_LEVEL,
    // frame control and status
    input wire logic TX_START,
    input wire logic RX_START,
    output logic BUSY,
    output logic RX_DONE,
    output logic RX_CRC_ERR,
    // rf side
    output logic TX_OUT,
    input wire logic RX_BIT_VALID,
    input wire logic RX_BIT
);
    import ccf_pkg::*;

    ccf_state_e state_reg, state_next;
    logic [7:0] car_reg, car_next, cnt_reg, cnt_next, flen_reg, flen_next, rxb_reg, rxb_next;
    logic [8:0] sh_reg, sh_next;
    logic [3:0] nb_reg, nb_next;
    logic [15:0] crc_reg, crc_next, hunt_reg, hunt_next;
    logic [2:0] rxn_reg, rxn_next;
    logic prev_reg, prev_next, tx_reg, tx_next, sync_reg, sync_next, done_reg, done_next;
    logic err_reg, err_next, busy_reg, busy_next, wack_reg, wack_next, rack_reg, rack_next;
    logic [7:0] rdat_reg, rdat_next;
    logic [PTR_W-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [LVL_W-1:0] lvl_reg, lvl_next;
    logic [7:0] mem_reg [FIFO_DEPTH];
    logic [7:0] per, half, qtr, head, push_data, nfetch;
    logic bit_end, level, par_on, full, empty, proc_wr, proc_rd, tx_pop, rx_push, push, pop, fetch;

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = b[7-i];
        return r;
    endfunction : rev8

    function automatic logic [15:0] crc_f(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (r[15] ^ b[i]) ? ((r << 1) ^ CRCF_POLY) : (r << 1);
        return r;
    endfunction : crc_f

    function automatic logic [15:0] crc_a(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRCA_POLY) : (r >> 1);
        return r;
    endfunction : crc_a

    // serial unit: bit count and shift pattern, first bit in bit 0
    function automatic logic [12:0] unit_of(input logic [7:0] b, input logic typef, input logic pon);
        if (typef)
            return {BITS_BYTE, 1'b0, rev8(b)};
        else if (pon)
            return {BITS_PAR, ~^b, b};
        else
            return {BITS_BYTE, 1'b0, b};
    endfunction : unit_of

    // type F has no 106 rate, so it falls back to its base rate
    always_comb
    begin
        unique case (RATE)
            R424: per = PER_424;
            R212: per = PER_212;
            default: per = MODE_TYPEF ? PER_212 : PER_106;
        endcase
    end

    assign half = per >> 1;
    assign qtr = per >> 2;
    assign bit_end = CARRIER_TICK && (car_reg == per - 8'h01);
    assign par_on = (RATE == R106) || PARITY_HI_EN;
    assign full = (lvl_reg == LVL_FULL);
    assign empty = (lvl_reg == '0);
    assign head = mem_reg[rp_reg];
    // processor cannot write during receive nor read during a frame, so each end of the buffer has one owner
    assign proc_wr = WR_REQ && !full && (state_reg != ST_RX);
    assign proc_rd = RD_REQ && !empty && (state_reg == ST_IDLE);
    assign push = proc_wr || rx_push;
    assign pop = proc_rd || tx_pop;
    assign push_data = proc_wr ? WR_DATA : rxb_next;

    // line level within the current bit
    always_comb
    begin
        if (MODE_TYPEF)
            level = (car_reg < half) ? sh_reg[0] : ~sh_reg[0];
        else if (state_reg == ST_EOF && nb_reg == BITS_ONE)
            level = 1'b1;
        else
            level = ~((sh_reg[0] && car_reg >= half && car_reg < half + qtr) ||
                      (!sh_reg[0] && !prev_reg && car_reg < qtr));
    end

    always_comb
    begin
        state_next = state_reg;
        car_next = car_reg;
        sh_next = sh_reg;
        nb_next = nb_reg;
        prev_next = prev_reg;
        cnt_next = cnt_reg;
        flen_next = flen_reg;
        crc_next = crc_reg;
        tx_next = tx_reg;
        hunt_next = hunt_reg;
        rxb_next = rxb_reg;
        rxn_next = rxn_reg;
        sync_next = sync_reg;
        done_next = 1'b0;
        err_next = err_reg;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        fetch = 1'b0;
        nfetch = (state_reg == ST_DATA) ? cnt_reg : 8'h00;
        if (state_reg == ST_IDLE)
        begin
            tx_next = ~MODE_TYPEF;
            car_next = '0;
            if (TX_START && MODE_TYPEF)
            begin
                state_next = ST_PRE;
                cnt_next = '0;
                crc_next = CRCF_INIT;
                {nb_next, sh_next} = unit_of(PRE_BYTE, 1'b1, 1'b0);
            end
            else if (TX_START)
            begin
                state_next = ST_SOF;
                crc_next = CRCA_INIT;
                prev_next = 1'b0;
                nb_next = BITS_ONE;
                sh_next = '0;
            end
            else if (RX_START && MODE_TYPEF)
            begin
                state_next = ST_RX;
                sync_next = 1'b0;
                hunt_next = '0;
                err_next = 1'b0;
            end
        end
        else if (state_reg == ST_RX)
        begin
            // hunting for the sync word drops the preamble without counting it
            if (RX_BIT_VALID && !sync_reg)
            begin
                hunt_next = {hunt_reg[14:0], RX_BIT};
                if (hunt_next == SYNC_WORD)
                begin
                    sync_next = 1'b1;
                    rxn_next = '0;
                    cnt_next = '0;
                    crc_next = CRCF_INIT;
                end
            end
            else if (RX_BIT_VALID)
            begin
                rxb_next = {rxb_reg[6:0], RX_BIT};
                rxn_next = rxn_reg + 3'h1;
                if (rxn_reg == RXN_LAST)
                begin
                    crc_next = crc_f(crc_reg, rxb_next);
                    cnt_next = cnt_reg + 8'h01;
                    if (cnt_reg == 8'h00)
                        flen_next = rxb_next;
                    if (cnt_reg == 8'h00 || cnt_reg < flen_reg)
                    begin
                        rx_push = !full;
                        err_next = err_reg || full;
                    end
                    if (cnt_reg != 8'h00 && cnt_reg == flen_reg + 8'h01)
                    begin
                        state_next = ST_IDLE;
                        done_next = 1'b1;
                        err_next = err_reg || full || (crc_next != CRCF_GOOD);
                    end
                end
            end
        end
        else if (CARRIER_TICK)
        begin
            car_next = bit_end ? '0 : car_reg + 8'h01;
            tx_next = level;
            if (bit_end && nb_reg != BITS_ONE)
            begin
                sh_next = sh_reg >> 1;
                nb_next = nb_reg - BITS_ONE;
                prev_next = sh_reg[0];
            end
            else if (bit_end)
            begin
                prev_next = sh_reg[0];
                unique case (state_reg)
                    ST_PRE:
                        if (cnt_reg == PRE_LAST)
                        begin
                            state_next = ST_SYNC;
                            cnt_next = '0;
                            {nb_next, sh_next} = unit_of(SYNC_HI, 1'b1, 1'b0);
                        end
                        else
                        begin
                            cnt_next = cnt_reg + 8'h01;
                            {nb_next, sh_next} = unit_of(PRE_BYTE, 1'b1, 1'b0);
                        end
                    ST_SYNC:
                        if (cnt_reg == 8'h00)
                        begin
                            cnt_next = 8'h01;
                            {nb_next, sh_next} = unit_of(SYNC_LO, 1'b1, 1'b0);
                        end
                        else
                        begin
                            state_next = ST_DATA;
                            fetch = 1'b1;
                        end
                    ST_SOF, ST_DATA:
                    begin
                        state_next = ST_DATA;
                        fetch = 1'b1;
                    end
                    ST_CRC:
                        if (cnt_reg == 8'h00)
                        begin
                            cnt_next = 8'h01;
                            {nb_next, sh_next} = unit_of(MODE_TYPEF ? crc_reg[7:0] : crc_reg[15:8], MODE_TYPEF, par_on);
                        end
                        else if (MODE_TYPEF)
                            state_next = ST_IDLE;
                        else
                        begin
                            state_next = ST_EOF;
                            nb_next = BITS_EOF;
                            sh_next = '0;
                        end
                    ST_EOF:
                        state_next = ST_IDLE;
                    ST_IDLE, ST_RX:
                        state_next = state_reg;
                endcase
                // first buffered byte is the length; type F stops after that many bytes
                if (fetch && (empty || (MODE_TYPEF && nfetch != 8'h00 && nfetch == flen_reg)))
                begin
                    state_next = ST_CRC;
                    cnt_next = '0;
                    {nb_next, sh_next} = unit_of(MODE_TYPEF ? crc_reg[15:8] : crc_reg[7:0], MODE_TYPEF, par_on);
                end
                else if (fetch)
                begin
                    tx_pop = 1'b1;
                    cnt_next = nfetch + 8'h01;
                    if (nfetch == 8'h00)
                        flen_next = head;
                    crc_next = MODE_TYPEF ? crc_f(crc_reg, head) : crc_a(crc_reg, head);
                    {nb_next, sh_next} = unit_of(head, MODE_TYPEF, par_on);
                end
            end
        end
        busy_next = (state_next != ST_IDLE);
        wack_next = proc_wr;
        rack_next = proc_rd;
        rdat_next = proc_rd ? head : rdat_reg;
        // local strobes, not push and pop, so this process never reads back its own outputs
        wp_next = (proc_wr || rx_push) ? wp_reg + PTR_ONE : wp_reg;
        rp_next = (proc_rd || tx_pop) ? rp_reg + PTR_ONE : rp_reg;
        lvl_next = lvl_reg + ((proc_wr || rx_push) ? LVL_ONE : '0) - ((proc_rd || tx_pop) ? LVL_ONE : '0);
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= ST_IDLE;
            {car_reg, cnt_reg, flen_reg, rxb_reg, sh_reg, nb_reg, crc_reg, hunt_reg, rxn_reg} <= '0;
            {prev_reg, sync_reg, done_reg, err_reg, busy_reg, wack_reg, rack_reg} <= '0;
            tx_reg <= 1'b1;
            {rdat_reg, wp_reg, rp_reg, lvl_reg} <= '0;
        end
        else if (CE)
        begin
            state_reg <= state_next;
            {car_reg, cnt_reg, flen_reg, rxb_reg, sh_reg, nb_reg, crc_reg, hunt_reg, rxn_reg} <=
                {car_next, cnt_next, flen_next, rxb_next, sh_next, nb_next, crc_next, hunt_next, rxn_next};
            {prev_reg, sync_reg, done_reg, err_reg, busy_reg, wack_reg, rack_reg} <=
                {prev_next, sync_next, done_next, err_next, busy_next, wack_next, rack_next};
            tx_reg <= tx_next;
            {rdat_reg, wp_reg, rp_reg, lvl_reg} <= {rdat_next, wp_next, rp_next, lvl_next};
        end
    end

    // storage has no reset; only the pointers define what is valid
    for (genvar g = 0; g < FIFO_DEPTH; g++)
    begin : g_mem
        always_ff @(posedge CLK_SYS)
        begin
            if (CE && push && wp_reg == PTR_W'(g))
                mem_reg[g] <= push_data;
        end
    end

    assign TX_OUT = tx_reg;
    assign BUSY = busy_reg;
    assign RX_DONE = done_reg;
    assign RX_CRC_ERR = err_reg;
    assign WR_ACK = wack_reg;
    assign RD_ACK = rack_reg;
    assign RD_DATA = rdat_reg;
    assign BUF_LEVEL = lvl_reg;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_pre_count: assert property ((CE && state_reg == ST_PRE && state_next == ST_SYNC) |-> cnt_reg == PRE_LAST)
        else $error("preamble length wrong");
    a_pre_to_sync: assert property ((CE && state_reg == ST_PRE && state_next != ST_PRE)
        |=> state_reg == ST_SYNC && sh_reg[7:0] == rev8(SYNC_HI)) else $error("sync high byte missing");
    a_frame_bytes: assert property ((CE && MODE_TYPEF && state_reg == ST_DATA && state_next == ST_CRC && !empty)
        |-> cnt_reg == flen_reg) else $error("frame byte count differs from length byte");
    a_crc_seed: assert property ((CE && state_reg == ST_IDLE && TX_START && MODE_TYPEF)
        |=> state_reg == ST_PRE && crc_reg == CRCF_INIT) else $error("checksum not preset");
    a_crc_msb: assert property ((CE && MODE_TYPEF && state_reg == ST_DATA && state_next == ST_CRC)
        |=> sh_reg[7:0] == rev8(crc_reg[15:8])) else $error("checksum high byte not first");
    a_buf_bound: assert property (lvl_reg <= LVL_FULL) else $error("buffer level above depth");
    a_parity_len: assert property ((CE && !MODE_TYPEF && RATE == R106 && tx_pop) |=> nb_reg == BITS_PAR)
        else $error("parity bit missing");
    a_bit_period: assert property ((CE && bit_end && state_reg != ST_IDLE) |=> car_reg == '0)
        else $error("bit period not restarted");
    a_miller_pause: assert property ((CE && CARRIER_TICK && !MODE_TYPEF && state_reg == ST_DATA
        && sh_reg[0] && car_reg == half) |=> !TX_OUT) else $error("no pause for a one");
    a_manch_half: assert property ((CE && CARRIER_TICK && MODE_TYPEF && state_reg == ST_DATA
        && car_reg == half) |=> TX_OUT == !sh_reg[0]) else $error("no mid-bit inversion");
    a_rx_strip: assert property (rx_push |-> sync_reg && state_reg == ST_RX)
        else $error("byte stored before sync");
endmodule : ccf_frame_codec

// ---- core/ccf_pkg.sv ----
// constants and types for the contactless frame codec
package ccf_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int LVL_W = 7;
    localparam logic [LVL_W-1:0] LVL_FULL = 7'h40;
    localparam logic [LVL_W-1:0] LVL_ONE = 7'h01;
    localparam logic [PTR_W-1:0] PTR_ONE = 6'h01;
    localparam logic [7:0] PRE_LAST = 8'h05;
    localparam logic [7:0] PRE_BYTE = 8'h00;
    localparam logic [7:0] SYNC_HI = 8'hb2;
    localparam logic [7:0] SYNC_LO = 8'h4d;
    localparam logic [15:0] SYNC_WORD = {SYNC_HI, SYNC_LO};
    localparam logic [15:0] CRCF_INIT = 16'h0000;
    localparam logic [15:0] CRCF_POLY = 16'h1021;
    localparam logic [15:0] CRCF_GOOD = 16'h0000;
    localparam logic [15:0] CRCA_INIT = 16'h6363;
    localparam logic [15:0] CRCA_POLY = 16'h8408;
    localparam logic [7:0] PER_106 = 8'h80;
    localparam logic [7:0] PER_212 = 8'h40;
    localparam logic [7:0] PER_424 = 8'h20;
    localparam logic [3:0] BITS_ONE = 4'h1;
    localparam logic [3:0] BITS_EOF = 4'h2;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_PAR = 4'h9;
    localparam logic [2:0] RXN_LAST = 3'h7;
    typedef enum logic [1:0] {R106, R212, R424} ccf_rate_e;
    typedef enum logic [2:0] {ST_IDLE, ST_SOF, ST_PRE, ST_SYNC, ST_DATA, ST_CRC, ST_EOF, ST_RX} ccf_state_e;
endpackage : ccf_pkg

// ---- tb/ccf_card_model.sv ----
// type f card model: decodes the reader line and sends demodulated bits back
`timescale 1ns/100ps
module ccf_card_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // reader line, bit period in carrier ticks, decoder enable
    input wire logic carrier_tick,
    input wire logic tx_out,
    input wire logic [7:0] period,
    input wire logic listen,
    // demodulated bits toward the reader
    output logic rx_bit_valid,
    output logic rx_bit,
    // decoded reader bytes
    output logic byte_stb,
    output logic [7:0] byte_val
);
    logic locked, last_tx;
    logic [7:0] ph;
    logic [2:0] nbit;
    initial
    begin
        rx_bit_valid = 1'b0;
        rx_bit = 1'b1;
    end
    // first rise of a frame is mid-bit of the leading zero, so phase locks there
    always @(posedge clk_sys)
    begin
        byte_stb <= 1'b0;
        last_tx <= tx_out;
        if (!rst_n || !listen)
            locked <= 1'b0;
        else if (!locked && tx_out && !last_tx)
        begin
            locked <= 1'b1;
            ph <= period >> 1;
            nbit <= 3'h1;
            byte_val <= 8'h00;
        end
        else if (locked && carrier_tick)
        begin
            ph <= ((ph + 8'h01) == period) ? 8'h00 : ph + 8'h01;
            // first half of a bit carries its value, sampled a quarter bit in
            if ((ph + 8'h01) == (period >> 2))
            begin
                byte_val <= {byte_val[6:0], tx_out};
                nbit <= nbit + 3'h1;
                byte_stb <= (nbit == 3'h7);
            end
        end
    end
    // released line shows the inverse of the last bit; gap must be at least 1
    task automatic send_byte(input logic [7:0] b, input int gap);
        for (int i = 7; i >= 0; i--)
        begin
            repeat (gap) @(posedge clk_sys);
            rx_bit_valid <= 1'b1;
            rx_bit <= b[i];
            @(posedge clk_sys);
            rx_bit_valid <= 1'b0;
            rx_bit <= ~b[i];
        end
    endtask : send_byte
endmodule : ccf_card_model

// ---- tb/contactless_frame_codec_tb.sv ----
// self-checking bench for the contactless frame codec
`timescale 1ns/100ps
module contactless_frame_codec_tb;
    import ccf_pkg::*;
    typedef struct {ccf_rate_e rate; logic [7:0] per; int n; logic [7:0] d [5];} ccf_row_s;
    // rate, expected bit period, bytes written, then the expected checksum
    ccf_row_s rows [3] = '{'{R424, 8'h20, 3, '{8'h03, 8'hab, 8'hcd, 8'h90, 8'h35}},
        '{R212, 8'h40, 2, '{8'h02, 8'h00, 8'h66, 8'h62, 8'h00}},
        '{R106, 8'h40, 1, '{8'h01, 8'h10, 8'h21, 8'h00, 8'h00}}};
    logic [7:0] rx_frame [14] = '{8'h5a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hb2, 8'h4d, 8'h03, 8'hab, 8'hcd, 8'h90, 8'h35};
    logic clk_sys, rst_n, mode_typef, parity_hi_en, carrier_tick, wr_req, rd_req, tx_start, rx_start;
    logic wr_ack, rd_ack, busy, rx_done, rx_crc_err, tx_out, rx_bit_valid, rx_bit, byte_stb, listen, ce;
    logic [7:0] wr_data, rd_data, byte_val, per, e;
    logic [LVL_W-1:0] buf_level;
    ccf_rate_e rate;
    int n_errors, tests_run, n_ticks, t0;
    logic [7:0] got_q [$];
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // carrier tick every second cycle keeps frames short
    always @(posedge clk_sys)
    begin
        carrier_tick <= ~carrier_tick;
        n_ticks += carrier_tick;
        if (byte_stb)
            got_q.push_back(byte_val);
    end
    ccf_frame_codec ccf_frame_codec_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
        .MODE_TYPEF(mode_typef), .RATE(rate), .PARITY_HI_EN(parity_hi_en), .CARRIER_TICK(carrier_tick),
        .WR_REQ(wr_req), .WR_DATA(wr_data), .WR_ACK(wr_ack), .RD_REQ(rd_req), .RD_DATA(rd_data),
        .RD_ACK(rd_ack), .BUF_LEVEL(buf_level), .TX_START(tx_start), .RX_START(rx_start), .BUSY(busy),
        .RX_DONE(rx_done), .RX_CRC_ERR(rx_crc_err), .TX_OUT(tx_out), .RX_BIT_VALID(rx_bit_valid),
        .RX_BIT(rx_bit));
    ccf_card_model ccf_card_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .carrier_tick(carrier_tick),
        .tx_out(tx_out), .period(per), .listen(listen), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .byte_stb(byte_stb), .byte_val(byte_val));
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_num(input int got, input int exp);
        tests_run++;
        if (got != exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_num
    // 0 busy low, 1 receive done, 2 line low, 3 line high
    task automatic wait_for(input int which);
        for (int i = 0; i < 50000; i++)
        begin
            @(posedge clk_sys);
            #1;
            if ((which == 0 && busy === 1'b0) || (which == 1 && rx_done === 1'b1) ||
                (which == 2 && tx_out === 1'b0) || (which == 3 && tx_out === 1'b1))
                return;
        end
        $display("wait ran out at %0t", $time);
        n_errors++;
        tally_and_finish();
    endtask : wait_for
    task automatic wr(input logic [7:0] b, input logic exp_ack);
        wr_req <= 1'b1;
        wr_data <= b;
        @(posedge clk_sys);
        wr_req <= 1'b0;
        #1;
        chk_byte({7'h00, wr_ack}, {7'h00, exp_ack});
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic exp_ack, input logic [7:0] exp_data);
        rd_req <= 1'b1;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        #1;
        chk_byte({7'h00, rd_ack}, {7'h00, exp_ack});
        if (exp_ack)
            chk_byte(rd_data, exp_data);
        @(posedge clk_sys);
    endtask : rd
    task automatic start_tx;
        tx_start <= 1'b1;
        @(posedge clk_sys);
        tx_start <= 1'b0;
    endtask : start_tx
    initial
    begin
        rst_n = 1'b0;
        mode_typef = 1'b1;
        parity_hi_en = 1'b1;
        carrier_tick = 1'b0;
        {wr_req, rd_req, tx_start, rx_start, listen} = 5'h00;
        ce = 1'b1;
        wr_data = 8'h00;
        rate = R106;
        per = 8'h40;
        {n_errors, tests_run, n_ticks} = {32'd0, 32'd0, 32'd0};
        repeat (8) @(posedge clk_sys);
        #1;
        chk_byte({7'h00, tx_out}, 8'h01);
        chk_byte({busy, wr_ack, rd_ack, rx_done, rx_crc_err, 3'h0}, 8'h00);
        chk_byte({1'b0, buf_level}, 8'h00);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_byte({7'h00, tx_out}, 8'h00);
        $display("test reset done");
        foreach (rows[r])
        begin
            got_q.delete();
            rate <= rows[r].rate;
            per <= rows[r].per;
            for (int i = 0; i < rows[r].n; i++)
                wr(rows[r].d[i], 1'b1);
            // a byte beyond the length must stay behind in the buffer
            if (r == 2)
                wr(8'h77, 1'b1);
            listen <= 1'b1;
            start_tx();
            wait_for(0);
            listen <= 1'b0;
            for (int i = 0; i < rows[r].n + 10; i++)
            begin
                e = (i < 6) ? 8'h00 : (i == 6) ? 8'hb2 : (i == 7) ? 8'h4d : rows[r].d[i - 8];
                chk_byte(got_q[i], e);
            end
            if (r == 2)
                rd(1'b1, 8'h77);
            $display("test type f transmit row %0d done", r);
        end
        for (int i = 0; i < 65; i++)
            wr(8'(i), i < 64);
        #1;
        chk_byte({1'b0, buf_level}, 8'h40);
        for (int i = 0; i < 65; i++)
            rd(i < 64, 8'(i));
        // enable low must freeze the buffer even against a legal write
        ce <= 1'b0;
        wr(8'h55, 1'b0);
        ce <= 1'b1;
        #1;
        chk_byte({1'b0, buf_level}, 8'h00);
        $display("test buffer fill and drain done");
        mode_typef <= 1'b0;
        for (int r = 0; r < 3; r++)
        begin
            rate <= ccf_rate_e'(r);
            // 212 runs without parity so the switch shows in the frame length
            parity_hi_en <= (r != 1);
            wr(8'hff, 1'b1);
            start_tx();
            wait_for(2);
            t0 = n_ticks;
            wait_for(3);
            chk_num(n_ticks - t0, 32 >> r);
            wait_for(2);
            chk_num(n_ticks - t0, 192 >> r);
            wait_for(0);
            // start bit, data byte, two checksum bytes, two end bits; nine bits a byte with parity
            chk_num(n_ticks - t0, ((r == 1) ? 27 : 30) * (128 >> r) - 1);
            chk_byte({1'b0, buf_level}, 8'h00);
        end
        $display("test type a pause timing done");
        mode_typef <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            rx_start <= 1'b1;
            @(posedge clk_sys);
            rx_start <= 1'b0;
            fork
                foreach (rx_frame[i])
                    ccf_card_model_inst.send_byte(rx_frame[i] ^ ((i == 13) ? 8'(k) : 8'h00), k ? 1 : 12);
                wait_for(1);
            join
            wait_for(0);
            chk_byte({7'h00, rx_crc_err}, 8'(k));
            if (k == 0)
            begin
                chk_byte({1'b0, buf_level}, 8'h03);
                for (int i = 9; i < 12; i++)
                    rd(1'b1, rx_frame[i]);
            end
        end
        $display("test type f receive done");
        tally_and_finish();
    end
endmodule : contactless_frame_codec_tb
